// file: hdl/dct_pkg.sv
package dct_pkg;

    // ---------------------------------------------------------------
    // register addresses on the special function register port
    // ---------------------------------------------------------------
    localparam logic [7:0] TIMER_RUN_FLAG_REG_ADDR  = 8'h88;
    localparam logic [7:0] TIMER_MODE_REG_ADDR      = 8'h89;
    localparam logic [7:0] TIMER_A_LOW_BYTE_ADDR    = 8'h8a;
    localparam logic [7:0] TIMER_B_LOW_BYTE_ADDR    = 8'h8b;
    localparam logic [7:0] TIMER_A_HIGH_BYTE_ADDR   = 8'h8c;
    localparam logic [7:0] TIMER_B_HIGH_BYTE_ADDR   = 8'h8d;
    localparam logic [7:0] TIMER_CLOCK_CONTROL_ADDR = 8'h8e;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] REG_RESET = 8'h00;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    // clock control: [7] aux_b high, [6] aux_b low, [5] aux_a high,
    // [4] aux_a low, [3] timer_b sel, [2] timer_a sel, [1:0] prescale
    localparam int CKC_AUX_B_HIGH = 7;
    localparam int CKC_AUX_B_LOW  = 6;
    localparam int CKC_AUX_A_HIGH = 5;
    localparam int CKC_AUX_A_LOW  = 4;
    localparam int CKC_TIMER_SEL0 = 2;   // timer_b at +1
    localparam int CKC_PRESCALE   = 0;
    // run/flag register: timer_a run at 4, flag at 5; timer_b +2
    localparam int RF_RUN0        = 4;
    localparam int RF_FLAG0       = 5;
    localparam int RF_STRIDE      = 2;
    // mode register: timer_a nibble [3:0], timer_b nibble [7:4]
    localparam int MODE_NIBBLE    = 4;
    localparam int LOW13_BITS     = 5;

    // ---------------------------------------------------------------
    // prescale encodings and division ratios
    // ---------------------------------------------------------------
    localparam logic [1:0] PSC_DIV12  = 2'h0;
    localparam logic [1:0] PSC_DIV4   = 2'h1;
    localparam logic [1:0] PSC_DIV48  = 2'h2;
    localparam logic [1:0] PSC_EXT8   = 2'h3;
    localparam logic [5:0] DIV12_LAST = 6'h0b;
    localparam logic [5:0] DIV4_LAST  = 6'h03;
    localparam logic [5:0] DIV48_LAST = 6'h2f;
    localparam logic [5:0] EXT8_LAST  = 6'h07;

    // ---------------------------------------------------------------
    // timer modes and per-timer configuration nibble
    // ---------------------------------------------------------------
    localparam logic [1:0] MODE_13BIT  = 2'h0;
    localparam logic [1:0] MODE_16BIT  = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT  = 2'h3;

    typedef struct packed {
        logic       gate_enable;
        logic       count_select;
        logic [1:0] mode;
    } dct_mode_cfg_type;

endpackage : dct_pkg

// file: hdl/dct_top.sv
`timescale 1ns/1ns
`default_nettype none
module dct_top (
    input  wire logic       ref_clk_i,
    input  wire logic       resetn_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    input  wire logic [1:0] count_pin_i,
    input  wire logic [1:0] gate_input_i,
    input  wire logic [1:0] gate_polarity_i,
    input  wire logic [1:0] irq_enable_i,
    input  wire logic [1:0] vector_ack_i,
    input  wire logic       ext_clock_i,
    output logic      [1:0] timer_irq_o,
    output logic            aux_a_low_clock_select_o,
    output logic            aux_a_high_clock_select_o,
    output logic            aux_b_low_clock_select_o,
    output logic            aux_b_high_clock_select_o
);

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [1:0] pin_prev;
    logic [1:0] gate_meta;
    logic [1:0] gate_sync;
    logic       ext_meta;
    logic       ext_sync;
    logic       ext_prev;

    // two flops before use; a third keeps the last level for edges
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_meta  <= 2'h0;
            pin_sync  <= 2'h0;
            pin_prev  <= 2'h0;
            gate_meta <= 2'h0;
            gate_sync <= 2'h0;
            ext_meta  <= 1'b0;
            ext_sync  <= 1'b0;
            ext_prev  <= 1'b0;
        end else begin
            pin_meta  <= count_pin_i;
            pin_sync  <= pin_meta;
            pin_prev  <= pin_sync;
            gate_meta <= gate_input_i;
            gate_sync <= gate_meta;
            ext_meta  <= ext_clock_i;
            ext_sync  <= ext_meta;
            ext_prev  <= ext_sync;
        end
    end

    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    logic [7:0] timer_clock_control;
    logic [7:0] timer_mode_reg;
    logic [1:0] run;
    logic [7:0] next_timer_clock_control;
    logic [7:0] next_timer_mode_reg;
    logic [1:0] next_run;
    logic       wr_ckc;
    logic       wr_mode;
    logic       wr_runflag;

    assign wr_ckc     = sfr_wr_i && (sfr_addr_i == dct_pkg::TIMER_CLOCK_CONTROL_ADDR);
    assign wr_mode    = sfr_wr_i && (sfr_addr_i == dct_pkg::TIMER_MODE_REG_ADDR);
    assign wr_runflag = sfr_wr_i && (sfr_addr_i == dct_pkg::TIMER_RUN_FLAG_REG_ADDR);

    // run bits only store; the counts are never touched by them
    always_comb begin
        next_timer_clock_control = wr_ckc ? sfr_wdata_i : timer_clock_control;
        next_timer_mode_reg      = wr_mode ? sfr_wdata_i : timer_mode_reg;
        next_run = run;
        if (wr_runflag) begin
            next_run[0] = sfr_wdata_i[dct_pkg::RF_RUN0];
            next_run[1] = sfr_wdata_i[dct_pkg::RF_RUN0 + dct_pkg::RF_STRIDE];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            timer_clock_control <= dct_pkg::REG_RESET;
            timer_mode_reg      <= dct_pkg::REG_RESET;
            run                 <= 2'h0;
        end else begin
            timer_clock_control <= next_timer_clock_control;
            timer_mode_reg      <= next_timer_mode_reg;
            run                 <= next_run;
        end
    end

    // aux selects go straight out of the control register flops
    assign aux_a_low_clock_select_o  = timer_clock_control[dct_pkg::CKC_AUX_A_LOW];
    assign aux_b_low_clock_select_o  = timer_clock_control[dct_pkg::CKC_AUX_B_LOW];
    assign aux_a_high_clock_select_o = timer_clock_control[dct_pkg::CKC_AUX_A_HIGH];
    assign aux_b_high_clock_select_o = timer_clock_control[dct_pkg::CKC_AUX_B_HIGH];

    // ---------------------------------------------------------------
    // shared prescaler
    // ---------------------------------------------------------------
    logic [1:0] prescale_select;
    logic [5:0] psc_count;
    logic [5:0] next_psc_count;
    logic [5:0] psc_last;
    logic       psc_step;
    logic       psc_tick;

    assign prescale_select = timer_clock_control[dct_pkg::CKC_PRESCALE +: 2];

    // external mode steps on synchronised rising edges only, so the
    // external clock must stay well below half the system clock
    always_comb begin
        psc_last = dct_pkg::DIV12_LAST;
        psc_step = 1'b1;
        psc_tick = 1'b0;
        case (prescale_select)
            dct_pkg::PSC_DIV12: psc_last = dct_pkg::DIV12_LAST;
            dct_pkg::PSC_DIV4:  psc_last = dct_pkg::DIV4_LAST;
            dct_pkg::PSC_DIV48: psc_last = dct_pkg::DIV48_LAST;
            default: begin
                psc_last = dct_pkg::EXT8_LAST;
                psc_step = ext_sync && !ext_prev;
            end
        endcase
        next_psc_count = psc_count;
        if (psc_step) begin
            if (psc_count >= psc_last) begin
                next_psc_count = 6'h00;
                psc_tick       = 1'b1;
            end else begin
                next_psc_count = psc_count + 6'h01;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            psc_count <= 6'h00;
        end else begin
            psc_count <= next_psc_count;
        end
    end

    // ---------------------------------------------------------------
    // the two counter/timers
    // ---------------------------------------------------------------
    logic [7:0] low_view  [2];
    logic [7:0] high_view [2];
    logic [1:0] flag_view;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_timer
            dct_pkg::dct_mode_cfg_type cfg;
            logic [7:0]  low;
            logic [7:0]  high;
            logic        flag;
            logic        irq;
            logic [7:0]  next_low;
            logic [7:0]  next_high;
            logic        next_flag;
            logic        next_irq;
            logic        gate_ok;
            logic        src_tick;
            logic        inc;
            logic        ovf;
            logic [12:0] wide13;
            logic [12:0] sum13;
            logic [15:0] sum16;
            logic [7:0]  low_addr;
            logic [7:0]  high_addr;

            assign cfg       = timer_mode_reg[gi*dct_pkg::MODE_NIBBLE +: dct_pkg::MODE_NIBBLE];
            assign low_addr  = (gi == 0) ? dct_pkg::TIMER_A_LOW_BYTE_ADDR : dct_pkg::TIMER_B_LOW_BYTE_ADDR;
            assign high_addr = (gi == 0) ? dct_pkg::TIMER_A_HIGH_BYTE_ADDR : dct_pkg::TIMER_B_HIGH_BYTE_ADDR;

            // enable and count source
            assign gate_ok  = !cfg.gate_enable || (gate_sync[gi] == gate_polarity_i[gi]);
            assign src_tick = cfg.count_select ? (pin_prev[gi] && !pin_sync[gi])
                            : (timer_clock_control[dct_pkg::CKC_TIMER_SEL0 + gi] ? 1'b1 : psc_tick);
            assign inc      = run[gi] && gate_ok && src_tick;
            assign wide13   = {high, low[dct_pkg::LOW13_BITS-1:0]};
            assign sum13    = wide13 + 13'h0001;
            assign sum16    = {high, low} + 16'h0001;

            // count step; a software byte write wins over the step
            always_comb begin
                next_low  = low;
                next_high = high;
                ovf       = 1'b0;
                if (inc) begin
                    case (cfg.mode)
                        dct_pkg::MODE_13BIT: begin
                            // upper low-byte bits are left as they are
                            next_low  = {low[7:dct_pkg::LOW13_BITS], sum13[dct_pkg::LOW13_BITS-1:0]};
                            next_high = sum13[12:dct_pkg::LOW13_BITS];
                            ovf       = &wide13;
                        end
                        dct_pkg::MODE_16BIT: begin
                            next_low  = sum16[7:0];
                            next_high = sum16[15:8];
                            ovf       = &{high, low};
                        end
                        dct_pkg::MODE_RELOAD: begin
                            ovf      = &low;
                            next_low = ovf ? high : (low + 8'h01);
                        end
                        default: begin
                            // split mode is not built; the timer holds still
                            ovf = 1'b0;
                        end
                    endcase
                end
                if (sfr_wr_i && sfr_addr_i == low_addr) begin
                    next_low = sfr_wdata_i;
                end
                if (sfr_wr_i && sfr_addr_i == high_addr) begin
                    next_high = sfr_wdata_i;
                end
                // set beats a same-cycle software or vector clear
                next_flag = flag;
                if (wr_runflag) begin
                    next_flag = sfr_wdata_i[dct_pkg::RF_FLAG0 + gi*dct_pkg::RF_STRIDE];
                end
                if (vector_ack_i[gi]) begin
                    next_flag = 1'b0;
                end
                if (ovf) begin
                    next_flag = 1'b1;
                end
                next_irq = next_flag && irq_enable_i[gi];
            end

            always_ff @(posedge ref_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    low  <= dct_pkg::REG_RESET;
                    high <= dct_pkg::REG_RESET;
                    flag <= 1'b0;
                    irq  <= 1'b0;
                end else begin
                    low  <= next_low;
                    high <= next_high;
                    flag <= next_flag;
                    irq  <= next_irq;
                end
            end

            assign low_view[gi]    = low;
            assign high_view[gi]   = high;
            assign flag_view[gi]   = flag;
            assign timer_irq_o[gi] = irq;
        end
    endgenerate

    // ---------------------------------------------------------------
    // read-back, registered one cycle after the address
    // ---------------------------------------------------------------
    logic [7:0] next_rdata;

    // unmapped addresses read zero so other blocks can share the port
    always_comb begin
        if (sfr_addr_i == dct_pkg::TIMER_CLOCK_CONTROL_ADDR) begin
            next_rdata = timer_clock_control;
        end else if (sfr_addr_i == dct_pkg::TIMER_MODE_REG_ADDR) begin
            next_rdata = timer_mode_reg;
        end else if (sfr_addr_i == dct_pkg::TIMER_RUN_FLAG_REG_ADDR) begin
            next_rdata = {flag_view[1], run[1], flag_view[0], run[0], 4'h0};
        end else if (sfr_addr_i == dct_pkg::TIMER_A_LOW_BYTE_ADDR) begin
            next_rdata = low_view[0];
        end else if (sfr_addr_i == dct_pkg::TIMER_B_LOW_BYTE_ADDR) begin
            next_rdata = low_view[1];
        end else if (sfr_addr_i == dct_pkg::TIMER_A_HIGH_BYTE_ADDR) begin
            next_rdata = high_view[0];
        end else if (sfr_addr_i == dct_pkg::TIMER_B_HIGH_BYTE_ADDR) begin
            next_rdata = high_view[1];
        end else begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sfr_rdata_o <= 8'h00;
        end else begin
            sfr_rdata_o <= next_rdata;
        end
    end

endmodule : dct_top
`default_nettype wire

// file: bench/dct_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module dct_top_sva (
    input wire logic       ref_clk_i,
    input wire logic       resetn_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic       sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic [1:0] irq_enable_i,
    input wire logic [1:0] vector_ack_i,
    input wire logic [1:0] timer_irq_o,
    input wire logic       aux_a_low_clock_select_o,
    input wire logic       aux_a_high_clock_select_o,
    input wire logic       aux_b_low_clock_select_o,
    input wire logic       aux_b_high_clock_select_o
);
    // ---------------------------------------------------------------
    // port checks, one clock domain
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    // decoded writes; the flag register write also clears or sets flags
    wire logic       ckc_wr;
    wire logic       rf_wr;
    wire logic [3:0] aux;
    assign ckc_wr = sfr_wr_i && (sfr_addr_i == dct_pkg::TIMER_CLOCK_CONTROL_ADDR);
    assign rf_wr  = sfr_wr_i && (sfr_addr_i == dct_pkg::TIMER_RUN_FLAG_REG_ADDR);
    assign aux    = {aux_b_high_clock_select_o, aux_b_low_clock_select_o,
                     aux_a_high_clock_select_o, aux_a_low_clock_select_o};

    a_irq_a_enable: assert property (timer_irq_o[0] |-> $past(irq_enable_i[0]))
        else $error("timer a irq without enable");
    a_irq_b_enable: assert property (timer_irq_o[1] |-> $past(irq_enable_i[1]))
        else $error("timer b irq without enable");
    // a clear in the same cycle as the check drops the request one edge later
    a_irq_flag_stands: assert property (timer_irq_o[0] && irq_enable_i[0] && !vector_ack_i[0]
        && !rf_wr |=> timer_irq_o[0])
        else $error("timer a irq dropped without clear");
    a_aux_low_write: assert property (ckc_wr |=> aux[0] == $past(sfr_wdata_i[4])
        && aux[2] == $past(sfr_wdata_i[6]))
        else $error("aux low select not written");
    a_aux_high_write: assert property (ckc_wr |=> aux[1] == $past(sfr_wdata_i[5])
        && aux[3] == $past(sfr_wdata_i[7]))
        else $error("aux high select not written");
    a_aux_sel_hold: assert property (!ckc_wr |=> $stable(aux))
        else $error("aux selects changed without write");
    a_unmapped_zero: assert property (!(sfr_addr_i inside {[8'h88:8'h8e]}) |=> sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_runflag_nibble: assert property (sfr_addr_i == dct_pkg::TIMER_RUN_FLAG_REG_ADDR
        |=> sfr_rdata_o[3:0] == 4'h0)
        else $error("run flag low nibble not zero");
    a_clock_ctl_read: assert property (sfr_addr_i == dct_pkg::TIMER_CLOCK_CONTROL_ADDR
        |=> sfr_rdata_o[7:4] == $past(aux))
        else $error("clock control readback differs from outputs");

    // main scenarios
    c_ckc_write: cover property (ckc_wr);
    c_irq_rise:  cover property ($rose(timer_irq_o[0]));
    c_ack_irq:   cover property (vector_ack_i[0] && timer_irq_o[0]);
endmodule : dct_top_sva

bind dct_top dct_top_sva u_sva (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .irq_enable_i(irq_enable_i),
    .vector_ack_i(vector_ack_i), .timer_irq_o(timer_irq_o),
    .aux_a_low_clock_select_o(aux_a_low_clock_select_o), .aux_a_high_clock_select_o(aux_a_high_clock_select_o),
    .aux_b_low_clock_select_o(aux_b_low_clock_select_o), .aux_b_high_clock_select_o(aux_b_high_clock_select_o));
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        ref_clk_i = 1'b0;
    logic        resetn_i  = 1'b0;
    logic        wr        = 1'b0;
    logic        ext_clk   = 1'b0;
    logic [7:0]  addr      = 8'h00;
    logic [7:0]  wdata     = 8'h00;
    logic [7:0]  rdata;
    logic [1:0]  pin       = 2'b11;
    logic [1:0]  gate      = 2'b11;
    logic [1:0]  pol       = 2'b00;
    logic [1:0]  ien       = 2'b00;
    logic [1:0]  ack       = 2'b00;
    logic [1:0]  irq;
    logic [3:0]  aux;
    logic [15:0] cnt;
    int          fail_count  = 0;
    int          checks_done = 0;
    int          lim [5] = '{480, 40, 120, 10, 12};

    dct_top dut (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .count_pin_i(pin), .gate_input_i(gate),
        .gate_polarity_i(pol), .irq_enable_i(ien), .vector_ack_i(ack), .ext_clock_i(ext_clk),
        .timer_irq_o(irq), .aux_a_low_clock_select_o(aux[0]), .aux_a_high_clock_select_o(aux[1]),
        .aux_b_low_clock_select_o(aux[2]), .aux_b_high_clock_select_o(aux[3]));

    // system clock 100 MHz; external clock free runs near 18.5 MHz, unrelated phase
    initial forever #5 ref_clk_i = ~ref_clk_i;
    initial forever #27 ext_clk = ~ext_clk;

    // ---------------------------------------------------------------
    // access and compare tasks
    // ---------------------------------------------------------------
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk

    // prescaler phase and write latency make counts loose by a few ticks
    task automatic near(input string n, input int e, input logic [15:0] g);
        checks_done++;
        if ((g >= 16'(e - 3) && g <= 16'(e + 3)) !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED %s exp %0d got %h", n, e, g);
        end
    endtask : near

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk_i);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        @(posedge ref_clk_i);
        #1 d = rdata;
    endtask : rd_reg

    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
        logic [7:0] d;
        rd_reg(a, d);
        chk(n, {8'h00, e}, {8'h00, d});
    endtask : rc

    // slow falling edges, low level held four cycles, high level five
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            pin <= 2'b00;
            repeat (4) @(posedge ref_clk_i);
            pin <= 2'b11;
            repeat (4) @(posedge ref_clk_i);
        end
    endtask : pulse

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        for (int a = 8'h87; a < 8'h90; a++) rc(8'(a), 8'h00, "reset_map");
        chk("aux_reset", 16'h0000, {12'h000, aux});
        $display("test reset done");
        foreach (lim[i]) begin
            wr_reg(dct_pkg::TIMER_CLOCK_CONTROL_ADDR, 8'h5a ^ 8'(i * 8'h33));
            rc(dct_pkg::TIMER_CLOCK_CONTROL_ADDR, 8'h5a ^ 8'(i * 8'h33), "clock_ctl");
            chk("aux_out", {12'h000, 4'((8'h5a ^ 8'(i * 8'h33)) >> 4)}, {12'h000, aux});
        end
        $display("test clock control done");
        // one table row per clock source: system clock, then prescale 00..11
        wr_reg(dct_pkg::TIMER_MODE_REG_ADDR, 8'h01);
        foreach (lim[i]) begin
            wr_reg(dct_pkg::TIMER_A_LOW_BYTE_ADDR, 8'h00);
            wr_reg(dct_pkg::TIMER_A_HIGH_BYTE_ADDR, 8'h00);
            wr_reg(dct_pkg::TIMER_CLOCK_CONTROL_ADDR, (i == 0) ? 8'h04 : 8'(i - 1));
            wr_reg(dct_pkg::TIMER_RUN_FLAG_REG_ADDR, 8'h10);
            repeat (478) @(posedge ref_clk_i);
            wr_reg(dct_pkg::TIMER_RUN_FLAG_REG_ADDR, 8'h00);
            rd_reg(dct_pkg::TIMER_A_LOW_BYTE_ADDR, cnt[7:0]);
            rd_reg(dct_pkg::TIMER_A_HIGH_BYTE_ADDR, cnt[15:8]);
            near("rate", lim[i], cnt);
        end
        $display("test clock rates done");
        // pins count while the clock selects point at the system clock
        wr_reg(dct_pkg::TIMER_CLOCK_CONTROL_ADDR, 8'h0c);
        wr_reg(dct_pkg::TIMER_MODE_REG_ADDR, 8'h64);
        wr_reg(dct_pkg::TIMER_A_HIGH_BYTE_ADDR, 8'hff);
        wr_reg(dct_pkg::TIMER_A_LOW_BYTE_ADDR, 8'h1d);
        wr_reg(dct_pkg::TIMER_B_HIGH_BYTE_ADDR, 8'h80);
        wr_reg(dct_pkg::TIMER_B_LOW_BYTE_ADDR, 8'hfe);
        ien <= 2'b01;
        wr_reg(dct_pkg::TIMER_RUN_FLAG_REG_ADDR, 8'h50);
        pulse(4);
        repeat (6) @(posedge ref_clk_i);
        rc(dct_pkg::TIMER_RUN_FLAG_REG_ADDR, 8'hf0, "flags");
        rc(dct_pkg::TIMER_A_HIGH_BYTE_ADDR, 8'h00, "a13_high");
        rd_reg(dct_pkg::TIMER_A_LOW_BYTE_ADDR, cnt[7:0]);
        chk("a13_low", 16'h0001, {11'h000, cnt[4:0]});
        rc(dct_pkg::TIMER_B_LOW_BYTE_ADDR, 8'h82, "reload_low");
        rc(dct_pkg::TIMER_B_HIGH_BYTE_ADDR, 8'h80, "reload_high");
        chk("irq_a", 16'h0001, {14'h0000, irq});
        @(posedge ref_clk_i);
        ack <= 2'b01;
        ien <= 2'b10;
        @(posedge ref_clk_i);
        ack <= 2'b00;
        repeat (2) @(posedge ref_clk_i);
        rc(dct_pkg::TIMER_RUN_FLAG_REG_ADDR, 8'hd0, "vector_clear");
        chk("irq_b", 16'h0002, {14'h0000, irq});
        wr_reg(dct_pkg::TIMER_RUN_FLAG_REG_ADDR, 8'h00);
        rc(dct_pkg::TIMER_RUN_FLAG_REG_ADDR, 8'h00, "soft_clear");
        $display("test pin counting done");
        // timer b gated, active low input held inactive first
        wr_reg(dct_pkg::TIMER_B_LOW_BYTE_ADDR, 8'h00);
        wr_reg(dct_pkg::TIMER_B_HIGH_BYTE_ADDR, 8'h00);
        wr_reg(dct_pkg::TIMER_MODE_REG_ADDR, 8'h93);
        wr_reg(dct_pkg::TIMER_A_LOW_BYTE_ADDR, 8'h00);
        wr_reg(dct_pkg::TIMER_RUN_FLAG_REG_ADDR, 8'h50);
        repeat (20) @(posedge ref_clk_i);
        rc(dct_pkg::TIMER_B_LOW_BYTE_ADDR, 8'h00, "gate_off");
        rc(dct_pkg::TIMER_A_LOW_BYTE_ADDR, 8'h00, "mode3_idle");
        @(posedge ref_clk_i);
        gate <= 2'b01;
        repeat (30) @(posedge ref_clk_i);
        gate <= 2'b11;
        repeat (5) @(posedge ref_clk_i);
        cnt = 16'h0000;
        rd_reg(dct_pkg::TIMER_B_LOW_BYTE_ADDR, cnt[7:0]);
        near("gate_width", 30, cnt);
        @(posedge ref_clk_i);
        pol <= 2'b10;
        repeat (20) @(posedge ref_clk_i);
        wr_reg(dct_pkg::TIMER_RUN_FLAG_REG_ADDR, 8'h00);
        rd_reg(dct_pkg::TIMER_B_LOW_BYTE_ADDR, cnt[7:0]);
        near("gate_polarity", 52, cnt);
        $display("test gating done");
        give_verdict();
    end

    // hang guard, about seven times the expected run
    initial begin
        #200000;
        fail_count++;
        $display("watchdog expired");
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
